// file: design/adcqs_pkg.sv
package adcqs_pkg;
  // table geometry
  localparam int unsigned TBL_DEPTH = 64;
  localparam int unsigned IDX_W = 7;
  localparam int unsigned CHAN_W = 6;
  localparam logic [5:0] EOQ_CODE = 6'h3F;
  localparam logic [6:0] TBL_END = 7'h40;
  localparam logic [6:0] Q1_START = 7'h00;
  localparam logic [6:0] BQ2_RST = 7'h00;

  // queue operating mode field codes; every other code is reserved
  localparam logic [2:0] MODE_DIS = 3'h0;
  localparam logic [2:0] MODE_SW_SS = 3'h1;
  localparam logic [2:0] MODE_EXT_SS = 3'h2;
  localparam logic [2:0] MODE_TMR_SS = 3'h3;

  // interval timer: 128 converter clocks shifted left by the select, up to 128K
  localparam logic [16:0] TMR_BASE = 17'h00080;
  localparam logic [3:0] TMR_SEL_MAX = 4'hA;
  localparam logic [7:0] PRESC_RST = 8'h00;

  typedef enum logic [2:0] {
    QS_IDLE = 3'h0,
    QS_ACTIVE = 3'h1,
    QS_PAUSED = 3'h2,
    QS_SUSP = 3'h3,
    QS_PEND = 3'h4
  } adcqs_qstat_t;

  typedef enum logic [3:0] {
    F_IDLE = 4'h1,
    F_FETCH = 4'h2,
    F_READ = 4'h4,
    F_CONV = 4'h8
  } adcqs_fsm_t;

  typedef struct packed {
    logic pause;
    logic [5:0] chan;
  } adcqs_ccw_t;

  typedef struct packed {
    logic wr;
    logic [2:0] mode;
    logic sse;
    logic edge_fall;
  } adcqs_ctl_t;

  typedef struct packed {
    logic cf;
    logic pf;
    logic tor;
  } adcqs_flag_t;

  typedef struct packed {
    adcqs_qstat_t st;
    adcqs_flag_t flg;
    logic [2:0] mode;
    logic sse_rd;
    logic [6:0] ptr;
  } adcqs_stat_t;
endpackage

// file: design/adcqs_ram.sv
`timescale 1ns/10ps
module adcqs_ram #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW = 6,
  parameter int unsigned W = 7
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_depth_chk
    $error("adcqs_ram: depth exceeds address range");
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// file: design/adcqs_seq.sv
`timescale 1ns/10ps
module adcqs_seq (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // queue control and flag clearing, index 0 is queue 1
  input wire adcqs_pkg::adcqs_ctl_t [1:0] q_ctl,
  input wire adcqs_pkg::adcqs_flag_t [1:0] q_clr,
  input wire logic [6:0] queue2_start_pointer,
  input wire logic [7:0] presc,
  input wire logic [3:0] tmr_sel,
  // trigger pins
  input wire logic [1:0] ext_trig_pin,
  // host access to the command table
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [5:0] host_addr,
  input wire adcqs_pkg::adcqs_ccw_t host_wdata,
  output adcqs_pkg::adcqs_ccw_t host_rdata,
  output logic host_ack_r,
  output logic presc_safe_r,
  // converter core
  input wire logic conv_done,
  output logic conv_start_r,
  output logic conv_abort_r,
  output logic conv_q_r,
  output logic [5:0] conv_chan_r,
  // status readback
  output adcqs_pkg::adcqs_stat_t [1:0] q_stat_r
);
  adcqs_pkg::adcqs_fsm_t fsm_r;
  adcqs_pkg::adcqs_fsm_t fsm_nxt;
  adcqs_pkg::adcqs_qstat_t st_r [2];
  adcqs_pkg::adcqs_qstat_t st_nxt [2];
  adcqs_pkg::adcqs_flag_t flg_r [2];
  adcqs_pkg::adcqs_flag_t flg_nxt [2];
  adcqs_pkg::adcqs_ccw_t ram_q;
  logic [2:0] mode_r [2];
  logic [6:0] ptr_r [2];
  logic [6:0] ptr_nxt [2];
  logic [1:0] sse_r;
  logic [1:0] sse_nxt;
  logic [1:0] mode_chg;
  logic [1:0] vmode;
  logic [1:0] trg;
  logic [1:0] start;
  logic [1:0] busy;
  logic [1:0] ovr;
  logic [1:0] fin;
  logic [1:0] pse;
  logic [1:0] adv;
  logic [1:0] pf_set;
  logic [1:0] resume;
  logic [1:0] ext_edge;
  logic tmr_exp;
  logic tmr_arm;
  logic cur_q_r;
  logic cur_q_nxt;
  logic look_r;
  logic pbit_r;
  logic [6:0] cur_idx;
  logic beyond;
  logic rd_eoq;
  logic susp2;
  logic abort_cur;
  logic pick1;
  logic pick2;
  logic fin_any;
  logic pse_any;
  logic go_conv;
  logic done_any;
  logic fetch_rd;
  logic host_go;
  logic ram_rd;
  logic [5:0] ram_ra;
  logic both_dis;

  adcqs_trig #(
    .NQ(2)
  ) u_trig (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ext_pin(ext_trig_pin),
    .edge_fall({q_ctl[1].edge_fall, q_ctl[0].edge_fall}),
    .tmr_arm(tmr_arm),
    .presc(presc),
    .tmr_sel(tmr_sel),
    .ext_edge_r(ext_edge),
    .tmr_exp_r(tmr_exp)
  );

  adcqs_ram #(
    .DEPTH(adcqs_pkg::TBL_DEPTH),
    .AW(6),
    .W($bits(adcqs_pkg::adcqs_ccw_t))
  ) u_ram (
    .clk(ref_clk),
    .wr_en(host_wr),
    .wr_addr(host_addr),
    .wr_data(host_wdata),
    .rd_en(ram_rd),
    .rd_addr(ram_ra),
    .rd_data(ram_q)
  );

  // host wait
  // sequencer fetch owns the read port; with both queues disabled it fetches only when a queue was disabled in the cycle the idle sequencer picked it
  assign fetch_rd = (fsm_r == adcqs_pkg::F_FETCH) && !beyond && !abort_cur;
  assign host_go = host_rd && !fetch_rd && !host_ack_r;
  assign ram_rd = fetch_rd || host_go;
  assign ram_ra = fetch_rd ? cur_idx[5:0] : host_addr;
  assign host_rdata = ram_q;
  assign both_dis = (mode_r[0] == adcqs_pkg::MODE_DIS) && (mode_r[1] == adcqs_pkg::MODE_DIS);
  assign tmr_arm = (mode_r[0] == adcqs_pkg::MODE_TMR_SS && sse_r[0])
                || (mode_r[1] == adcqs_pkg::MODE_TMR_SS && sse_r[1]);

  assign susp2 = start[0] && (st_r[1] == adcqs_pkg::QS_ACTIVE);
  assign abort_cur = (fsm_r != adcqs_pkg::F_IDLE)
                  && (cur_q_r ? (mode_chg[1] || susp2) : mode_chg[0]);

  assign cur_idx = ptr_r[cur_q_r];
  assign beyond = (cur_idx >= adcqs_pkg::TBL_END);
  assign rd_eoq = (ram_q.chan == adcqs_pkg::EOQ_CODE)
               || (!cur_q_r && (cur_idx == queue2_start_pointer));

  assign fin_any = !abort_cur && (((fsm_r == adcqs_pkg::F_FETCH) && beyond)
                || ((fsm_r == adcqs_pkg::F_READ) && rd_eoq));
  assign pse_any = !abort_cur && (fsm_r == adcqs_pkg::F_READ) && !rd_eoq && look_r;
  assign go_conv = !abort_cur && (fsm_r == adcqs_pkg::F_READ) && !rd_eoq && !look_r;
  assign done_any = !abort_cur && (fsm_r == adcqs_pkg::F_CONV) && conv_done;

  assign pick1 = (st_r[0] == adcqs_pkg::QS_ACTIVE);
  assign pick2 = !pick1 && !start[0] && busy[1];

  always_comb begin
    fsm_nxt = fsm_r;
    cur_q_nxt = cur_q_r;
    case (fsm_r)
      adcqs_pkg::F_IDLE: begin
        if (pick1) begin
          fsm_nxt = adcqs_pkg::F_FETCH;
          cur_q_nxt = 1'b0;
        end else if (pick2) begin
          fsm_nxt = adcqs_pkg::F_FETCH;
          cur_q_nxt = 1'b1;
        end
      end
      adcqs_pkg::F_FETCH: fsm_nxt = beyond ? adcqs_pkg::F_IDLE : adcqs_pkg::F_READ;
      adcqs_pkg::F_READ: fsm_nxt = go_conv ? adcqs_pkg::F_CONV : adcqs_pkg::F_IDLE;
      adcqs_pkg::F_CONV: fsm_nxt = conv_done ? adcqs_pkg::F_FETCH : adcqs_pkg::F_CONV;
      default: fsm_nxt = adcqs_pkg::F_IDLE;
    endcase
    if (abort_cur) begin
      fsm_nxt = adcqs_pkg::F_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fsm_r <= adcqs_pkg::F_IDLE;
      cur_q_r <= 1'b0;
      look_r <= 1'b0;
      pbit_r <= 1'b0;
    end else begin
      fsm_r <= fsm_nxt;
      cur_q_r <= cur_q_nxt;
      look_r <= done_any ? pbit_r
              : ((fsm_r == adcqs_pkg::F_READ) || (fsm_nxt == adcqs_pkg::F_IDLE)) ? 1'b0
              : look_r;
      pbit_r <= go_conv ? ram_q.pause : pbit_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      conv_start_r <= 1'b0;
      conv_abort_r <= 1'b0;
      conv_q_r <= 1'b0;
      conv_chan_r <= 6'h00;
      host_ack_r <= 1'b0;
      presc_safe_r <= 1'b1;
    end else begin
      conv_start_r <= go_conv;
      conv_abort_r <= abort_cur && (fsm_r == adcqs_pkg::F_CONV);
      conv_q_r <= go_conv ? cur_q_r : conv_q_r;
      conv_chan_r <= go_conv ? ram_q.chan : conv_chan_r;
      host_ack_r <= host_go;
      presc_safe_r <= both_dis;
    end
  end

  for (genvar q = 0; q < 2; q++) begin : g_q
    logic sse_load;
    logic sw_trig;
    logic [6:0] start_idx;

    assign start_idx = (q == 0) ? adcqs_pkg::Q1_START : queue2_start_pointer;
    assign fin[q] = fin_any && (cur_q_r == 1'(q));
    assign pse[q] = pse_any && (cur_q_r == 1'(q));
    assign adv[q] = done_any && (cur_q_r == 1'(q));
    assign pf_set[q] = adv[q] && pbit_r;
    assign resume[q] = (q == 1) && (fsm_r == adcqs_pkg::F_IDLE) && pick2;

    assign mode_chg[q] = q_ctl[q].wr && (q_ctl[q].mode != mode_r[q]);
    assign vmode[q] = (mode_r[q] == adcqs_pkg::MODE_SW_SS)
                   || (mode_r[q] == adcqs_pkg::MODE_EXT_SS)
                   || (mode_r[q] == adcqs_pkg::MODE_TMR_SS);
    assign sse_load = q_ctl[q].wr && !mode_chg[q] && (st_r[q] == adcqs_pkg::QS_IDLE)
                   && q_ctl[q].sse;
    assign sw_trig = (mode_r[q] == adcqs_pkg::MODE_SW_SS)
                  && ((st_r[q] == adcqs_pkg::QS_IDLE) || (st_r[q] == adcqs_pkg::QS_PAUSED));
    assign trg[q] = vmode[q] && sse_r[q] && !mode_chg[q]
                 && (sw_trig
                 || ((mode_r[q] == adcqs_pkg::MODE_EXT_SS) && ext_edge[q])
                 || ((mode_r[q] == adcqs_pkg::MODE_TMR_SS) && tmr_exp));
    assign busy[q] = (st_r[q] == adcqs_pkg::QS_ACTIVE) || (st_r[q] == adcqs_pkg::QS_PEND)
                  || (st_r[q] == adcqs_pkg::QS_SUSP);
    assign start[q] = trg[q] && !busy[q];
    assign ovr[q] = trg[q] && busy[q] && (mode_r[q] != adcqs_pkg::MODE_SW_SS);

    assign sse_nxt[q] = mode_chg[q] ? q_ctl[q].sse
                      : fin[q] ? 1'b0
                      : sse_load ? 1'b1
                      : sse_r[q];

    assign st_nxt[q] = mode_chg[q] ? adcqs_pkg::QS_IDLE
                     : fin[q] ? adcqs_pkg::QS_IDLE
                     : pse[q] ? adcqs_pkg::QS_PAUSED
                     : ((q == 1) && susp2) ? adcqs_pkg::QS_SUSP
                     : start[q] ? (((q == 1) && ((st_r[0] == adcqs_pkg::QS_ACTIVE) || start[0]))
                                  ? adcqs_pkg::QS_PEND : adcqs_pkg::QS_ACTIVE)
                     : resume[q] ? adcqs_pkg::QS_ACTIVE
                     : st_r[q];

    assign ptr_nxt[q] = (mode_chg[q] || (start[q] && (st_r[q] == adcqs_pkg::QS_IDLE)))
                      ? start_idx
                      : adv[q] ? ptr_r[q] + 7'h01
                      : ptr_r[q];

    assign flg_nxt[q] = (flg_r[q] & ~q_clr[q]) | {fin[q], pf_set[q], ovr[q]};

    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        mode_r[q] <= adcqs_pkg::MODE_DIS;
        sse_r[q] <= 1'b0;
        st_r[q] <= adcqs_pkg::QS_IDLE;
        ptr_r[q] <= adcqs_pkg::Q1_START;
        flg_r[q] <= '0;
        q_stat_r[q] <= '0;
      end else begin
        mode_r[q] <= q_ctl[q].wr ? q_ctl[q].mode : mode_r[q];
        sse_r[q] <= sse_nxt[q];
        st_r[q] <= st_nxt[q];
        ptr_r[q] <= ptr_nxt[q];
        flg_r[q] <= flg_nxt[q];
        q_stat_r[q] <= {st_nxt[q], flg_nxt[q], q_ctl[q].wr ? q_ctl[q].mode : mode_r[q],
                        1'b0, ptr_nxt[q]};
      end
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_eoq_no_conv: assert property (
    (fsm_r == adcqs_pkg::F_READ) && rd_eoq |=> !conv_start_r ##1 !conv_start_r)
    else $error("conversion started on end word");
  a_beyond_fin: assert property (
    (fsm_r == adcqs_pkg::F_FETCH) && beyond && !abort_cur
    |=> (st_r[cur_q_r] == adcqs_pkg::QS_IDLE) && flg_r[cur_q_r].cf)
    else $error("beyond-table start did not complete");
  a_dis_idle: assert property (
    (mode_r[0] == adcqs_pkg::MODE_DIS) |-> (st_r[0] == adcqs_pkg::QS_IDLE))
    else $error("disabled queue 1 not idle");
  a_rsv_idle: assert property (
    !vmode[1] |-> (st_r[1] == adcqs_pkg::QS_IDLE) && (!conv_start_r || !conv_q_r))
    else $error("reserved queue 2 ran");
  a_sse_hold: assert property (
    sse_r[0] && busy[0] && !mode_chg[0] && !fin[0] |=> sse_r[0])
    else $error("enable dropped while running");
  a_sw_no_ovr: assert property (
    (mode_r[0] == adcqs_pkg::MODE_SW_SS) && !q_ctl[0].wr && !q_clr[0].tor
    |=> flg_r[0].tor == $past(flg_r[0].tor))
    else $error("overrun set in software mode");
  a_q2_pend: assert property (
    trg[1] && (st_r[0] == adcqs_pkg::QS_ACTIVE) && (st_r[1] == adcqs_pkg::QS_IDLE)
    |=> (st_r[1] == adcqs_pkg::QS_PEND))
    else $error("queue 2 not pending");
  a_q2_susp: assert property (
    susp2 && !mode_chg[1] && !fin[1] && !pse[1] |=> (st_r[1] == adcqs_pkg::QS_SUSP)
    && (fsm_r == adcqs_pkg::F_IDLE || cur_q_r == 1'b0))
    else $error("queue 2 not suspended");
  a_pause_look: assert property (
    done_any && pbit_r
    |=> look_r && (fsm_r == adcqs_pkg::F_FETCH) && flg_r[cur_q_r].pf)
    else $error("pause not taken");
  a_sw_resume: assert property (
    (st_r[0] == adcqs_pkg::QS_PAUSED) && (mode_r[0] == adcqs_pkg::MODE_SW_SS) && !q_ctl[0].wr
    |=> (st_r[0] != adcqs_pkg::QS_PAUSED))
    else $error("software mode stalled in pause");
  a_host_nowait: assert property (
    host_rd && both_dis && !host_ack_r |=> host_ack_r)
    else $error("host waited with queues disabled");
  a_q2_ptr: assert property (
    start[1] && (st_r[1] == adcqs_pkg::QS_IDLE) |=> ptr_r[1] == $past(queue2_start_pointer))
    else $error("queue 2 did not start at its pointer");
endmodule

// file: design/adcqs_trig.sv
`timescale 1ns/10ps
module adcqs_trig #(
  parameter int unsigned NQ = 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // external trigger pins and polarity
  input wire logic [NQ-1:0] ext_pin,
  input wire logic [NQ-1:0] edge_fall,
  // interval timer
  input wire logic tmr_arm,
  input wire logic [7:0] presc,
  input wire logic [3:0] tmr_sel,
  // trigger pulses
  output logic [NQ-1:0] ext_edge_r,
  output logic tmr_exp_r
);
  logic [7:0] div_r;
  logic converter_clock_en;
  logic [16:0] tcnt_r;
  logic [3:0] sel_c;
  logic [16:0] lim;

  assign converter_clock_en = (div_r == presc);
  assign sel_c = (tmr_sel > adcqs_pkg::TMR_SEL_MAX) ? adcqs_pkg::TMR_SEL_MAX : tmr_sel;
  assign lim = (adcqs_pkg::TMR_BASE << sel_c) - 17'h00001;

  always_ff @(posedge ref_clk) begin
    if (!rstn || converter_clock_en) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // timer restarts whenever no queue is armed for it
  always_ff @(posedge ref_clk) begin
    if (!rstn || !tmr_arm) begin
      tcnt_r <= 17'h00000;
      tmr_exp_r <= 1'b0;
    end else begin
      tmr_exp_r <= converter_clock_en && (tcnt_r == lim);
      if (converter_clock_en) begin
        tcnt_r <= (tcnt_r == lim) ? 17'h00000 : tcnt_r + 17'h00001;
      end
    end
  end

  for (genvar q = 0; q < NQ; q++) begin : g_pin
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic edge_r;
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        edge_r <= 1'b0;
      end else begin
        s1_r <= ext_pin[q];
        s2_r <= s1_r;
        s3_r <= s2_r;
        edge_r <= edge_fall[q] ? (s3_r && !s2_r) : (!s3_r && s2_r);
      end
    end
    // one process per bit keeps each flop single-driven
    assign ext_edge_r[q] = edge_r;
  end
endmodule

// file: tb/adcqs_core_model.sv
`timescale 1ns/10ps
module adcqs_core_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // converter handshake
  input wire logic conv_start_r,
  input wire logic conv_abort_r,
  input wire logic [7:0] lat,
  output logic conv_done
);
  logic [7:0] cnt_r;
  // an abort drops the conversion with no done pulse, as the real core does
  always_ff @(posedge ref_clk) begin
    if (!rstn || conv_abort_r) begin
      cnt_r <= 8'h00;
    end else if (conv_start_r) begin
      cnt_r <= lat;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign conv_done = (cnt_r == 8'h01) && !conv_start_r;
endmodule

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
  localparam logic [2:0] SW = adcqs_pkg::MODE_SW_SS;
  localparam logic [2:0] EXT = adcqs_pkg::MODE_EXT_SS;
  localparam adcqs_pkg::adcqs_qstat_t IDLE = adcqs_pkg::QS_IDLE;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  adcqs_pkg::adcqs_ctl_t [1:0] q_ctl = '0;
  adcqs_pkg::adcqs_flag_t [1:0] q_clr = '0;
  logic [6:0] bq2 = 7'h0A;
  logic [1:0] pin = 2'h0;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [5:0] host_addr = 6'h00;
  adcqs_pkg::adcqs_ccw_t host_wdata = '0;
  adcqs_pkg::adcqs_ccw_t host_rdata;
  adcqs_pkg::adcqs_stat_t [1:0] q_stat_r;
  logic host_ack_r, presc_safe_r, conv_done, conv_start_r, conv_abort_r, conv_q_r;
  logic [5:0] conv_chan_r;
  logic [5:0] last_chan = 6'h00;
  logic last_q = 1'b0;
  logic [7:0] lat = 8'h04;
  logic [2:0] inact [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  int errors = 0;
  int total_checks = 0;
  int n_conv = 0;
  int n_abort = 0;
  int c0, a0, w;

  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (conv_start_r === 1'b1) begin
      n_conv <= n_conv + 1;
      last_chan <= conv_chan_r;
      last_q <= conv_q_r;
    end
    if (conv_abort_r === 1'b1) begin
      n_abort <= n_abort + 1;
    end
  end

  adcqs_seq i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .q_ctl(q_ctl), .q_clr(q_clr),
    .queue2_start_pointer(bq2), .presc(8'h00), .tmr_sel(4'h0), .ext_trig_pin(pin),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_ack_r(host_ack_r),
    .presc_safe_r(presc_safe_r), .conv_done(conv_done), .conv_start_r(conv_start_r),
    .conv_abort_r(conv_abort_r), .conv_q_r(conv_q_r), .conv_chan_r(conv_chan_r),
    .q_stat_r(q_stat_r)
  );

  adcqs_core_model i_core (
    .ref_clk(ref_clk), .rstn(rstn), .conv_start_r(conv_start_r),
    .conv_abort_r(conv_abort_r), .lat(lat), .conv_done(conv_done)
  );

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic conversion_command_word(input logic [5:0] a, input logic p, input logic [5:0] ch);
    @(negedge ref_clk);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = {p, ch};
    @(negedge ref_clk);
    host_wr = 1'b0;
  endtask

  task automatic ctl(input int q, input logic [2:0] m, input logic s, input logic ef);
    @(negedge ref_clk);
    q_ctl[q] = {1'b1, m, s, ef};
    @(negedge ref_clk);
    q_ctl[q].wr = 1'b0;
  endtask

  task automatic clr(input int q);
    @(negedge ref_clk);
    q_clr[q] = '1;
    @(negedge ref_clk);
    q_clr[q] = '0;
    @(negedge ref_clk);
    chk("flags", 8'h00, 8'(q_stat_r[q].flg));
  endtask

  task automatic pulse(input int q);
    pin[q] = ~pin[q];
    repeat (8) @(negedge ref_clk);
    pin[q] = ~pin[q];
    repeat (8) @(negedge ref_clk);
  endtask

  // idle is only reached once the completion flag shows as well
  task automatic wt(input int q, input adcqs_pkg::adcqs_qstat_t s);
    for (int i = 0; i < 3000; i++) begin
      if (q_stat_r[q].st === s && (s != IDLE || q_stat_r[q].flg.cf === 1'b1)) begin
        break;
      end
      @(negedge ref_clk);
    end
    chk("state", 8'(s), 8'(q_stat_r[q].st));
  endtask

  task automatic scan(input int q, input int nc, input logic pf);
    c0 = n_conv;
    ctl(q, SW, 1'b1, 1'b0);
    wt(q, IDLE);
    repeat (3) @(negedge ref_clk);
    chk("conv", 8'(nc), 8'(n_conv - c0));
    chk("cf", 8'h01, 8'(q_stat_r[q].flg.cf));
    chk("pf", 8'(pf), 8'(q_stat_r[q].flg.pf));
    chk("tor", 8'h00, 8'(q_stat_r[q].flg.tor));
    chk("sse_rd", 8'h00, 8'(q_stat_r[q].sse_rd));
    chk("other cf", 8'h00, 8'(q_stat_r[1 - q].flg.cf));
    clr(q);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    $display("ERROR watchdog expected done seen timeout");
    summarize();
  end

  initial begin
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    chk("safe", 8'h01, 8'(presc_safe_r));
    conversion_command_word(6'h03, 1'b1, 6'h2A);
    @(negedge ref_clk);
    host_rd = 1'b1;
    w = 0;
    do begin
      @(negedge ref_clk);
      w++;
    end while (host_ack_r !== 1'b1 && w < 9);
    host_rd = 1'b0;
    chk("rd wait", 8'h01, 8'(w));
    chk("rdata", 8'h6A, 8'(host_rdata));
    foreach (inact[i]) begin
      c0 = n_conv;
      ctl(0, inact[i], 1'b1, 1'b0);
      ctl(1, inact[i], 1'b1, 1'b0);
      pulse(0);
      pulse(1);
      repeat (150) @(negedge ref_clk);
      chk("conv", 8'h00, 8'(n_conv - c0));
      chk("st1", 8'h00, 8'(q_stat_r[0].st));
      chk("st2", 8'h00, 8'(q_stat_r[1].st));
    end
    conversion_command_word(6'h00, 1'b0, 6'h05);
    conversion_command_word(6'h01, 1'b1, 6'h06);
    conversion_command_word(6'h02, 1'b0, 6'h07);
    conversion_command_word(6'h03, 1'b0, 6'h3F);
    conversion_command_word(6'h3F, 1'b0, 6'h09);
    scan(0, 3, 1'b1);
    chk("chan", 8'h07, 8'(last_chan));
    chk("conv_q", 8'h00, 8'(last_q));
    scan(0, 3, 1'b1);
    bq2 = 7'h02;
    scan(0, 2, 1'b1);
    bq2 = 7'h01;
    scan(0, 1, 1'b0);
    bq2 = 7'h00;
    scan(0, 0, 1'b0);
    bq2 = 7'h3F;
    scan(1, 1, 1'b0);
    chk("chan", 8'h09, 8'(last_chan));
    chk("conv_q", 8'h01, 8'(last_q));
    bq2 = 7'h50;
    scan(1, 0, 1'b0);
    conversion_command_word(6'h00, 1'b0, 6'h3F);
    bq2 = 7'h0A;
    scan(0, 0, 1'b0);
    bq2 = 7'h00;
    scan(0, 0, 1'b0);
    conversion_command_word(6'h00, 1'b0, 6'h05);
    bq2 = 7'h0A;
    lat = 8'h28;
    for (int ef = 0; ef < 2; ef++) begin
      pin[0] = 1'(ef);
      ctl(0, EXT, 1'b0, 1'(ef));
      c0 = n_conv;
      pulse(0);
      repeat (20) @(negedge ref_clk);
      chk("conv", 8'h00, 8'(n_conv - c0));
      ctl(0, EXT, 1'b1, 1'(ef));
      repeat (20) @(negedge ref_clk);
      chk("conv", 8'h00, 8'(n_conv - c0));
      pulse(0);
      pulse(0);
      wt(0, adcqs_pkg::QS_PAUSED);
      chk("tor", 8'h01, 8'(q_stat_r[0].flg.tor));
      chk("conv", 8'h02, 8'(n_conv - c0));
      pulse(0);
      wt(0, IDLE);
      chk("conv", 8'h03, 8'(n_conv - c0));
      clr(0);
    end
    c0 = n_conv;
    ctl(0, adcqs_pkg::MODE_TMR_SS, 1'b1, 1'b0);
    repeat (100) @(negedge ref_clk);
    chk("conv", 8'h00, 8'(n_conv - c0));
    wt(0, adcqs_pkg::QS_PAUSED);
    wt(0, IDLE);
    chk("conv", 8'h03, 8'(n_conv - c0));
    clr(0);
    bq2 = 7'h02;
    c0 = n_conv;
    a0 = n_abort;
    ctl(1, SW, 1'b1, 1'b0);
    repeat (12) @(negedge ref_clk);
    ctl(0, SW, 1'b1, 1'b0);
    repeat (4) @(negedge ref_clk);
    chk("abort", 8'h01, 8'(n_abort - a0));
    chk("st2", 8'(adcqs_pkg::QS_SUSP), 8'(q_stat_r[1].st));
    wt(0, IDLE);
    wt(1, IDLE);
    chk("conv", 8'h04, 8'(n_conv - c0));
    clr(0);
    clr(1);
    c0 = n_conv;
    ctl(0, SW, 1'b1, 1'b0);
    repeat (12) @(negedge ref_clk);
    ctl(1, SW, 1'b1, 1'b0);
    @(negedge ref_clk);
    chk("st2", 8'(adcqs_pkg::QS_PEND), 8'(q_stat_r[1].st));
    wt(0, IDLE);
    wt(1, IDLE);
    chk("conv", 8'h03, 8'(n_conv - c0));
    chk("tor2", 8'h00, 8'(q_stat_r[1].flg.tor));
    clr(0);
    clr(1);
    c0 = n_conv;
    ctl(0, SW, 1'b1, 1'b0);
    repeat (12) @(negedge ref_clk);
    ctl(0, SW, 1'b0, 1'b0);
    wt(0, IDLE);
    chk("conv", 8'h02, 8'(n_conv - c0));
    clr(0);
    c0 = n_conv;
    a0 = n_abort;
    ctl(0, SW, 1'b1, 1'b0);
    repeat (12) @(negedge ref_clk);
    ctl(0, adcqs_pkg::MODE_DIS, 1'b0, 1'b0);
    ctl(1, adcqs_pkg::MODE_DIS, 1'b0, 1'b0);
    repeat (60) @(negedge ref_clk);
    chk("abort", 8'h01, 8'(n_abort - a0));
    chk("conv", 8'h01, 8'(n_conv - c0));
    chk("st1", 8'h00, 8'(q_stat_r[0].st));
    chk("safe", 8'h01, 8'(presc_safe_r));
    summarize();
  end
endmodule
